// ---- logic/ddrca_ctl.sv ----
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/1ps
module ddrca_ctl (
    input wire logic clk,
    input wire logic arst_n,
    input wire ddrca_pkg::ddrca_req_type req,
    output logic [31:0] rdata,
    output ddrca_pkg::ddrca_pins_type pins,
    input wire logic alert_n
);
    typedef struct packed {
        ddrca_pkg::ddrca_st_type st;
        logic ph;
        ddrca_pkg::ddrca_pins_type pins;
        ddrca_pkg::ddrca_ctrl_type ctrl;
        ddrca_pkg::ddrca_cmd_type cmd;
        logic alert;
        logic refused;
        logic [31:0] rdata;
        logic al_s1;
        logic al_s2;
    } ddrca_state_type;

    localparam ddrca_state_type S_RST = '{
        st: ddrca_pkg::ST_IDLE, ph: 1'b0, pins: ddrca_pkg::PINS_RST,
        ctrl: ddrca_pkg::CTRL_RST, cmd: '0, alert: 1'b0,
        refused: 1'b0, rdata: 32'h00000000, al_s1: 1'b1, al_s2: 1'b1};

    ddrca_state_type s_r;
    ddrca_state_type s_nxt;

    logic c_act_n;
    logic [17:0] c_a;
    logic [1:0] c_bg;
    logic [2:0] c_id;
    logic [2:0] c_idle;
    logic [ddrca_pkg::PAR_W-1:0] par_vec;
    logic par_odd;
    logic is_rw;

    // Command pin images built from the pending command
    assign c_act_n = ~s_r.cmd.act;
    // All 18 address pins are used; A_USED_MASK clears none of them
    assign c_a = s_r.cmd.a & ddrca_pkg::A_USED_MASK;
    // Upper bank group bit forced low on x16
    assign c_bg = {s_r.cmd.bg[1] & ~s_r.ctrl.x16, s_r.cmd.bg[0]};
    // Stack pins: chip ID on 3DS, unused on x16
    assign c_id = (s_r.ctrl.s3ds && !s_r.ctrl.x16) ? s_r.cmd.cid : 3'h0;
    // Dual die: C0 is CKE1, C1 is CS1_n, C2 is ODT1
    assign c_idle = (s_r.ctrl.ddp && !s_r.ctrl.x16) ?
        {s_r.ctrl.odt1, 1'b1, s_r.ctrl.cke1} : 3'h0;
    // Covered set excludes CS_n, CKE and ODT
    assign par_vec = {c_act_n, c_a, s_r.cmd.ba, c_bg, c_id};
    // Read and write: ACT_n high, RAS_n high, CAS_n low
    assign is_rw = ~s_r.cmd.act & s_r.cmd.a[16] & ~s_r.cmd.a[15];

    ddrca_parity #(
        .W(ddrca_pkg::PAR_W)
    ) u_par (
        .bits(par_vec),
        .odd(par_odd)
    );

    always_comb begin
        ddrca_pkg::ddrca_cmd_type wcmd;
        wcmd = '0;
        s_nxt = s_r;
        s_nxt.ph = ~s_r.ph;
        s_nxt.pins.ck_t = ~s_r.ph;
        s_nxt.pins.ck_c = s_r.ph;
        s_nxt.al_s1 = alert_n;
        s_nxt.al_s2 = s_r.al_s1;
        s_nxt.rdata = 32'h00000000;
        if (req.rd) begin
            case (req.addr)
                ddrca_pkg::CTRL_OFS: begin
                    s_nxt.rdata = {20'h00000, s_r.ctrl};
                end
                ddrca_pkg::CMD_OFS: begin
                    s_nxt.rdata = {5'h00, s_r.cmd};
                end
                ddrca_pkg::STAT_OFS: begin
                    s_nxt.rdata[ddrca_pkg::STAT_BUSY] =
                        (s_r.st != ddrca_pkg::ST_IDLE);
                    s_nxt.rdata[ddrca_pkg::STAT_ALERT] = s_r.alert;
                    s_nxt.rdata[ddrca_pkg::STAT_REFUSED] = s_r.refused;
                    s_nxt.rdata[ddrca_pkg::STAT_ALERT_LVL] = ~s_r.al_s2;
                end
                default: begin
                    s_nxt.rdata = 32'h00000000;
                end
            endcase
        end
        if (req.wr) begin
            case (req.addr)
                ddrca_pkg::CTRL_OFS: begin
                    s_nxt.ctrl = req.wdata[11:0];
                end
                ddrca_pkg::CMD_OFS: begin
                    wcmd = req.wdata[26:0];
                    // Accesses need CKE high on the pins
                    if (s_r.st != ddrca_pkg::ST_IDLE ||
                        (!wcmd.act && wcmd.a[16] && !wcmd.a[15] &&
                         !s_r.pins.cke)) begin
                        s_nxt.refused = 1'b1;
                    end else begin
                        s_nxt.cmd = wcmd;
                        s_nxt.st = ddrca_pkg::ST_WAIT;
                    end
                end
                ddrca_pkg::STAT_OFS: begin
                    if (req.wdata[ddrca_pkg::STAT_ALERT]) begin
                        s_nxt.alert = 1'b0;
                    end
                    if (req.wdata[ddrca_pkg::STAT_REFUSED]) begin
                        s_nxt.refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Alert seen while parity is on; a new alert beats a clear
        if (!s_r.al_s2 && s_r.ctrl.par_en) begin
            s_nxt.alert = 1'b1;
        end
        // Pins move as ck_t falls, so the device samples on its rise
        if (s_r.ph) begin
            s_nxt.pins.reset_n = s_r.ctrl.rst_rel;
            s_nxt.pins.odt = s_r.ctrl.odt;
            s_nxt.pins.dm_n = s_r.ctrl.dm_en ?
                {s_r.ctrl.dm_n[1] | ~s_r.ctrl.x16, s_r.ctrl.dm_n[0]} :
                ddrca_pkg::DM_OFF;
            case (s_r.st)
                ddrca_pkg::ST_IDLE: begin
                    // CKE only moves between commands
                    s_nxt.pins.cke = s_r.ctrl.cke;
                    if (!(s_r.ctrl.s3ds && !s_r.ctrl.x16)) begin
                        s_nxt.pins.c = c_idle;
                    end
                end
                ddrca_pkg::ST_WAIT: begin
                    s_nxt.pins.act_n = c_act_n;
                    s_nxt.pins.a = c_a;
                    s_nxt.pins.ba = s_r.cmd.ba;
                    s_nxt.pins.bg = c_bg;
                    s_nxt.pins.par = s_r.ctrl.par_en & par_odd;
                    if (s_r.ctrl.ddp && !s_r.ctrl.x16 && s_r.cmd.die1) begin
                        s_nxt.pins.cs_n = 1'b1;
                        s_nxt.pins.c = {c_idle[2], 1'b0, c_idle[0]};
                    end else begin
                        s_nxt.pins.cs_n = 1'b0;
                        s_nxt.pins.c = (s_r.ctrl.s3ds && !s_r.ctrl.x16) ?
                            c_id : c_idle;
                    end
                    s_nxt.st = ddrca_pkg::ST_DRIVE;
                end
                ddrca_pkg::ST_DRIVE: begin
                    // Deselect after one clock so nothing repeats
                    s_nxt.pins.cs_n = 1'b1;
                    s_nxt.pins.par = 1'b0;
                    s_nxt.pins.c = (s_r.ctrl.s3ds && !s_r.ctrl.x16) ?
                        s_r.pins.c : c_idle;
                    s_nxt.st = ddrca_pkg::ST_IDLE;
                end
                default: begin
                    s_nxt.st = ddrca_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= S_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata = s_r.rdata;
    assign pins = s_r.pins;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    chk_pins_on_fall: assert property (
        $changed(pins.cs_n) |-> !pins.ck_t)
    else $error("command pins changed off the falling clock");

    chk_cs_one_ck: assert property (
        $fell(pins.cs_n) |-> !pins.cs_n [*2] ##1 pins.cs_n)
    else $error("chip select not held for exactly one ck period");

    chk_parity_even: assert property (
        !pins.cs_n && s_r.ctrl.par_en && !s_r.ctrl.s3ds |->
        ^{pins.act_n, pins.a, pins.ba, pins.bg, pins.par} == 1'b0)
    else $error("command parity is odd");

    chk_rw_cke_high: assert property (
        !pins.cs_n && pins.act_n && pins.a[16] && !pins.a[15] |->
        pins.cke)
    else $error("read or write issued with CKE low");

    chk_cke_steady: assert property (
        s_r.st == ddrca_pkg::ST_DRIVE |-> $stable(pins.cke))
    else $error("CKE moved during a command");

    chk_x16_bg_low: assert property (
        !pins.cs_n && s_r.ctrl.x16 |-> !pins.bg[1] && pins.c == 3'h0)
    else $error("x16 drove upper bank group or stack pins");

    chk_act_rows: assert property (
        $fell(pins.cs_n) && s_r.cmd.act |->
        !pins.act_n && pins.a[16:14] == s_r.cmd.a[16:14])
    else $error("activate did not carry row bits");

    chk_nonact_cmd: assert property (
        $fell(pins.cs_n) && !s_r.cmd.act |-> pins.act_n)
    else $error("ordinary command drove ACT_n low");

    chk_alert_sticky: assert property (
        !s_r.al_s2 && s_r.ctrl.par_en |=> s_r.alert [*2])
    else $error("alert not captured");

    chk_reset_follow: assert property (
        !s_r.ctrl.rst_rel |-> ##[0:2] !pins.reset_n)
    else $error("reset pin not asserted");

    chk_cmd_launch: assert property (
        s_r.st == ddrca_pkg::ST_WAIT |-> ##[1:2] s_r.st ==
        ddrca_pkg::ST_DRIVE)
    else $error("command not launched in time");

    cov_activate: cover property (
        $fell(pins.cs_n) && !pins.act_n);
    cov_read_write: cover property (
        $fell(pins.cs_n) && pins.act_n && pins.a[16] && !pins.a[15]);
    cov_refused: cover property ($rose(s_r.refused));
    cov_alert: cover property ($rose(s_r.alert));
endmodule : ddrca_ctl

// ---- logic/ddrca_pkg.sv ----
// Operation
// - ACT_n and CS_n low: RAS_n, CAS_n, WE_n carry row bits A16, A15, A14
// - ACT_n high with CS_n low: RAS_n, CAS_n, WE_n are command signals
// - Bank address picks the bank within the group for ACT, RD, WR, PRE
// - Bank address with bank group picks the mode register on MRS
// - Bank group picks the group; upper bit unused on x16 parts
// - Stacked 4H/8H x4/x8: stack inputs are chip ID selects; unused on x16
// - Dual-die package: stack inputs are second die CKE, CS and ODT
// - CKE stays high throughout every read and write access; the code checks the CKE pin, which can fall as the command is taken
// - Mask low discards a write beat; x16 has upper and lower masks
// - Parity covers ACT_n, address, bank, group, 3DS stack IDs only
package ddrca_pkg;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CMD_OFS = 8'h04;
    localparam logic [7:0] STAT_OFS = 8'h08;
    localparam logic [17:0] A_USED_MASK = 18'h3FFFF;
    localparam logic [1:0] DM_OFF = 2'h3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_ALERT = 1;
    localparam int STAT_REFUSED = 2;
    localparam int STAT_ALERT_LVL = 3;
    localparam int PAR_W = 26;

    typedef struct packed {
        logic odt1;
        logic cke1;
        logic [1:0] dm_n;
        logic dm_en;
        logic s3ds;
        logic ddp;
        logic x16;
        logic par_en;
        logic odt;
        logic cke;
        logic rst_rel;
    } ddrca_ctrl_type;

    typedef struct packed {
        logic die1;
        logic act;
        logic [2:0] cid;
        logic [1:0] bg;
        logic [1:0] ba;
        logic [17:0] a;
    } ddrca_cmd_type;

    typedef struct packed {
        logic ck_t;
        logic ck_c;
        logic reset_n;
        logic cke;
        logic cs_n;
        logic act_n;
        logic [17:0] a;
        logic [1:0] ba;
        logic [1:0] bg;
        logic [2:0] c;
        logic odt;
        logic par;
        logic [1:0] dm_n;
    } ddrca_pins_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ddrca_req_type;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DRIVE = 3'b100
    } ddrca_st_type;

    localparam ddrca_ctrl_type CTRL_RST = '0;
    localparam ddrca_pins_type PINS_RST = '{
        ck_t: 1'b0, ck_c: 1'b1, reset_n: 1'b0, cke: 1'b0, cs_n: 1'b1,
        act_n: 1'b1, a: 18'h00000, ba: 2'h0, bg: 2'h0, c: 3'h0,
        odt: 1'b0, par: 1'b0, dm_n: 2'h3};
endpackage : ddrca_pkg

// ---- logic/ddrca_parity.sv ----
`timescale 1ns/1ps
module ddrca_parity #(
    parameter int W = 8
) (
    input wire logic [W-1:0] bits,
    output logic odd
);
    // Driving this as the parity bit makes the total even
    assign odd = ^bits;
endmodule : ddrca_parity

// ---- bench/ddrca_dev_model.sv ----
`timescale 1ns/1ps
// Device side: a plain x4/x8 part without stacking
module ddrca_dev_model (
    input wire ddrca_pkg::ddrca_pins_type pins,
    input wire logic par_on,
    input wire logic inj_err,
    output logic alert_n,
    output logic [22:0] cap,
    output int ncmd
);
    int hold;
    logic odd;
    initial begin
        alert_n = 1'b1;
        cap = '0;
        ncmd = 0;
        hold = 0;
    end
    // Sample where the true clock rises
    always @(posedge pins.ck_t or negedge pins.reset_n) begin
        if (!pins.reset_n) begin
            alert_n <= 1'b1;
            ncmd <= 0;
            hold <= 0;
        end else begin
            if (hold > 0) begin
                hold <= hold - 1;
            end else begin
                alert_n <= 1'b1;
            end
            // Deselect or gated buffers carry no command
            if (!pins.cs_n && pins.cke) begin
                // Row bits or command bits ride the same pins
                cap <= {pins.act_n, pins.a, pins.ba, pins.bg};
                ncmd <= ncmd + 1;
                // Even parity over covered pins only
                odd = ^{pins.act_n, pins.a, pins.ba, pins.bg, pins.par};
                if ((odd ^ inj_err) && par_on) begin
                    alert_n <= 1'b0;
                    hold <= 6;
                end
            end
        end
    end
    // Mask and termination pins are not modelled here
endmodule : ddrca_dev_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic clk;
    logic arst_n;
    logic alert_n;
    logic inj_err;
    logic par_on;
    logic x16;
    ddrca_pkg::ddrca_req_type req;
    ddrca_pkg::ddrca_pins_type pins;
    logic [31:0] rdata;
    logic [31:0] v;
    logic [22:0] cap;
    int ncmd;
    int n0;
    int cyc;
    int miscompares;
    int checks;
    ddrca_ctl u_dut (.clk(clk), .arst_n(arst_n), .req(req),
        .rdata(rdata), .pins(pins), .alert_n(alert_n));
    ddrca_dev_model u_dev (.pins(pins), .par_on(par_on),
        .inj_err(inj_err), .alert_n(alert_n), .cap(cap), .ncmd(ncmd));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic test_done;
        if (miscompares == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        req.addr <= ad;
        req.wdata <= d;
        req.wr <= 1'b1;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] ad);
        @(posedge clk);
        req.addr <= ad;
        req.rd <= 1'b1;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask : rd
    task automatic cmd(input logic act, input logic [17:0] a,
                       input logic [1:0] ba, input logic [1:0] bg);
        logic [22:0] e;
        int n;
        n = ncmd;
        wr(ddrca_pkg::CMD_OFS, {5'h00, act, 3'h0, bg, ba, a});
        v = 32'h00000001;
        for (int k = 0; k < 20 && v[0]; k++) begin
            rd(ddrca_pkg::STAT_OFS);
        end
        e = {~act, a, ba, (x16 ? {1'b0, bg[0]} : bg)};
        chk(64'(cap), 64'(e));
        chk(64'(ncmd - n), 64'h1);
    endtask : cmd
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            test_done();
        end
    end
    initial begin
        void'($urandom(32'h462ED0AA));
        req = '0;
        inj_err = 1'b0;
        par_on = 1'b1;
        x16 = 1'b0;
        arst_n = 1'b0;
        repeat (2) @(posedge clk);
        chk(64'(pins), 64'(ddrca_pkg::PINS_RST));
        arst_n <= 1'b1;
        rd(ddrca_pkg::CTRL_OFS);
        chk(64'(v), 64'h0);
        rd(8'h0C);
        chk(64'(v), 64'h0);
        wr(ddrca_pkg::CTRL_OFS, 32'h0000000B);
        for (int i = 0; i < 8; i++) begin
            if (i == 6) begin
                wr(ddrca_pkg::CTRL_OFS, 32'h0000001B);
                x16 = 1'b1;
            end
            cmd(i[0], 18'($urandom), 2'($urandom), 2'($urandom));
        end
        rd(ddrca_pkg::STAT_OFS);
        chk(64'(v[2:0]), 64'h0);
        inj_err <= 1'b1;
        cmd(1'b1, 18'h2AAAA, 2'h1, 2'h1);
        inj_err <= 1'b0;
        repeat (6) @(posedge clk);
        rd(ddrca_pkg::STAT_OFS);
        chk(64'(v[1]), 64'h1);
        repeat (20) @(posedge clk);
        wr(ddrca_pkg::STAT_OFS, 32'h00000002);
        rd(ddrca_pkg::STAT_OFS);
        chk(64'(v[3:1]), 64'h0);
        wr(ddrca_pkg::CTRL_OFS, 32'h000006AF);
        repeat (4) @(posedge clk);
        chk(64'(pins.cke), 64'h1);
        chk(64'(pins.odt), 64'h1);
        chk(64'(pins.dm_n), 64'h2);
        chk(64'(pins.c), 64'h3);
        wr(ddrca_pkg::CTRL_OFS, 32'h00000009);
        repeat (4) @(posedge clk);
        chk(64'(pins.cke), 64'h0);
        n0 = ncmd;
        wr(ddrca_pkg::CMD_OFS, 32'h00010000);
        repeat (6) @(posedge clk);
        rd(ddrca_pkg::STAT_OFS);
        chk(64'(v[2:0]), 64'h4);
        chk(64'(ncmd - n0), 64'h0);
        wr(ddrca_pkg::STAT_OFS, 32'h00000004);
        rd(ddrca_pkg::STAT_OFS);
        chk(64'(v[2:0]), 64'h0);
        test_done();
    end
endmodule : tb
